// [rtl/mav_consts.vh]
// Offsets, codes, reset values and field layout of the algorithm variable bank
`ifndef MAV_CONSTS_VH
`define MAV_CONSTS_VH

// ************************************************************
// Register indices (byte address is four times the index)
// ************************************************************
`define MAV_IX_MOTOR_SEQUENCER_STATUS 11'h190
`define MAV_IX_TACH_PULSE_SPEED 11'h196
`define MAV_IX_DC_SUPPLY_CURRENT_CALC 11'h410
`define MAV_IX_WINDING_A_CURRENT 11'h440
`define MAV_IX_WINDING_B_CURRENT 11'h442
`define MAV_IX_WINDING_C_CURRENT 11'h444
`define MAV_IX_SENSE_AMP_GAIN_READBACK 11'h468
`define MAV_IX_VOLTAGE_SENSE_RANGE_READBACK 11'h472
`define MAV_IX_MOTOR_SUPPLY_LEVEL 11'h474
`define MAV_IX_WINDING_A_VOLTAGE 11'h47a
`define MAV_IX_WINDING_B_VOLTAGE 11'h47c
`define MAV_IX_WINDING_C_VOLTAGE 11'h47e
`define MAV_IX_COMMUTATION_SINE 11'h4b6
`define MAV_IX_COMMUTATION_COSINE 11'h4b8
`define MAV_IX_ALPHA_AXIS_CURRENT 11'h4d2
`define MAV_IX_BETA_AXIS_CURRENT 11'h4d4
`define MAV_IX_ALPHA_AXIS_VOLTAGE 11'h4d6
`define MAV_IX_BETA_AXIS_VOLTAGE 11'h4d8
`define MAV_IX_D_AXIS_CURRENT_MEAS 11'h4e2
`define MAV_IX_Q_AXIS_CURRENT_MEAS 11'h4e4
`define MAV_IX_D_AXIS_VOLTAGE 11'h4e6
`define MAV_IX_Q_AXIS_VOLTAGE 11'h4e8
`define MAV_IX_ALIGN_CURRENT_TARGET 11'h524
`define MAV_IX_OPEN_LOOP_RATE_TARGET 11'h53c
`define MAV_IX_OPEN_LOOP_CURRENT_TARGET 11'h54c
`define MAV_IX_FEEDBACK_LOOP_RATE_TARGET 11'h5d2
`define MAV_IX_D_AXIS_CURRENT_TARGET 11'h604
`define MAV_IX_Q_AXIS_CURRENT_TARGET 11'h606
`define MAV_IX_SPIN_DETECT_STATUS 11'h680
`define MAV_IX_SPIN_DETECT_RATE 11'h68a
`define MAV_IX_POSITION_DETECT_STATUS 11'h6be
`define MAV_IX_POSITION_DETECT_ANGLE 11'h702
`define MAV_IX_D_AXIS_BACKEMF 11'h748
`define MAV_IX_Q_AXIS_BACKEMF 11'h74a
`define MAV_IX_ROTOR_RATE_ESTIMATE 11'h758
`define MAV_IX_ROTOR_ANGLE_ESTIMATE 11'h75c
`define MAV_IX_IRQ_STATUS 11'h7e0
`define MAV_IX_IRQ_MASK 11'h7e2

// ************************************************************
// Reset values and widths
// ************************************************************
`define MAV_RST_WORD 32'h00000000
`define MAV_RST_HALF 16'h0000
`define MAV_RST_EVT 5'h00
`define MAV_NARROW_W 16
`define MAV_PU_FRAC_BITS 27
`define MAV_PU_CURRENT_DIV 8

// ************************************************************
// Motor sequencer state codes
// ************************************************************
`define MAV_ST_IDLE 16'h0000
`define MAV_ST_SPIN_DETECT 16'h0001
`define MAV_ST_TRISTATE 16'h0002
`define MAV_ST_BRAKE_ON_START 16'h0003
`define MAV_ST_POSITION_DETECT 16'h0004
`define MAV_ST_SLOW_FIRST_CYCLE 16'h0005
`define MAV_ST_ALIGN 16'h0006
`define MAV_ST_OPEN_LOOP 16'h0007
`define MAV_ST_CL_UNALIGNED 16'h0008
`define MAV_ST_CL_ALIGNED 16'h0009
`define MAV_ST_CL_ACTIVE_BRAKING 16'h000a
`define MAV_ST_SOFT_STOP 16'h000b
`define MAV_ST_RECIRCULATE_STOP 16'h000c
`define MAV_ST_BRAKE_ON_STOP 16'h000d
`define MAV_ST_FAULT 16'h000e
`define MAV_ST_PX_STOP_CHECK 16'h000f
`define MAV_ST_PX_STOP_WAIT 16'h0010
`define MAV_ST_PX_BRAKE 16'h0011
`define MAV_ST_PX_PARAM_INIT 16'h0012
`define MAV_ST_PX_RL_MEASURE 16'h0013
`define MAV_ST_PX_STALL_MEASURE 16'h0014
`define MAV_ST_PX_UNUSED 16'h0015
`define MAV_ST_PX_TORQUE_MODE 16'h0016
`define MAV_ST_PX_FAULT 16'h0017

// ************************************************************
// Readback encodings
// ************************************************************
`define MAV_GAIN_X8 16'h0000
`define MAV_GAIN_X4 16'h0001
`define MAV_GAIN_X2 16'h0002
`define MAV_GAIN_X1 16'h0003
`define MAV_VRANGE_MAX 16'h0002

// ************************************************************
// Interrupt event bits
// ************************************************************
`define MAV_EV_STATE_CHANGE 0
`define MAV_EV_FAULT_ENTRY 1
`define MAV_EV_SPIN_STATUS 2
`define MAV_EV_POS_STATUS 3
`define MAV_EV_REJECTED 4
`define MAV_EV_COUNT 5

`endif

// [rtl/mav_sticky.v]
// Sticky event flag, set wins over clear
`timescale 1ns/100ps
`default_nettype none

module mav_sticky (
  input wire clk_i,
  input wire rstn_i,
  input wire set_i,
  input wire clr_i,
  output reg q_o
);

  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      q_o <= 1'b0;
    end else if (set_i) begin
      q_o <= 1'b1;
    end else if (clr_i) begin
      q_o <= 1'b0;
    end
  end

endmodule // mav_sticky

`default_nettype wire

// [rtl/mav_bank.v]
// Read-only bank of live motor algorithm variables with event interrupt
`timescale 1ns/100ps
`default_nettype none
`include "mav_consts.vh"

// Functional notes
// - Sequencer status: 16 bits at 190h, read-only, zero after reset.
// - Start-up codes: idle 0h through open loop 7h.
// - Run and stop codes: closed loop unaligned 8h through fault Eh.
// - Extraction codes Fh to 17h; code 15h is never accepted.
// - Every variable register read-only, reads zero until first algorithm update; IRQ mask and status take host writes.
// - Winding A, B, C currents: 32-bit words at 440h, 442h, 444h.
// - d/q currents at 4E2h, 4E4h; d/q voltages at 4E6h, 4E8h.
// - Rotor rate estimate at 758h, rotor angle estimate at 75Ch.
// - Spin and position detect status: 16 bits at 680h, 6BEh, zero at reset.
// - Current words are per-unit, 27 fraction bits, scaled by base over 8.
// - Gain readback codes 0h to 3h mean times 8, 4, 2, 1.

module mav_bank #(
  parameter DW = 32,
  parameter NSLOT = 36
) (
  input wire clk_i,
  input wire rstn_i,
  input wire [12:0] addr_i,
  input wire [31:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [31:0] rdata_o,
  input wire upd_i,
  input wire [10:0] upd_index_i,
  input wire [31:0] upd_data_i,
  output reg irq_o
);

  // ************************************************************
  // Slot numbers that the event logic watches
  // ************************************************************
  localparam [5:0] SL_SEQ = 6'd0;
  localparam [5:0] SL_GAIN = 6'd6;
  localparam [5:0] SL_VRANGE = 6'd7;
  localparam [5:0] SL_SPIN = 6'd28;
  localparam [5:0] SL_POS = 6'd30;

  // ************************************************************
  // Index decode, shared by host and algorithm side
  // ************************************************************
  function [6:0] slot_of;
    input [10:0] ix;
    begin
      case (ix)
        `MAV_IX_MOTOR_SEQUENCER_STATUS: slot_of = {1'b1, SL_SEQ};
        `MAV_IX_TACH_PULSE_SPEED: slot_of = {1'b1, 6'd1};
        `MAV_IX_DC_SUPPLY_CURRENT_CALC: slot_of = {1'b1, 6'd2};
        `MAV_IX_WINDING_A_CURRENT: slot_of = {1'b1, 6'd3};
        `MAV_IX_WINDING_B_CURRENT: slot_of = {1'b1, 6'd4};
        `MAV_IX_WINDING_C_CURRENT: slot_of = {1'b1, 6'd5};
        `MAV_IX_SENSE_AMP_GAIN_READBACK: slot_of = {1'b1, SL_GAIN};
        `MAV_IX_VOLTAGE_SENSE_RANGE_READBACK: slot_of = {1'b1, SL_VRANGE};
        `MAV_IX_MOTOR_SUPPLY_LEVEL: slot_of = {1'b1, 6'd8};
        `MAV_IX_WINDING_A_VOLTAGE: slot_of = {1'b1, 6'd9};
        `MAV_IX_WINDING_B_VOLTAGE: slot_of = {1'b1, 6'd10};
        `MAV_IX_WINDING_C_VOLTAGE: slot_of = {1'b1, 6'd11};
        `MAV_IX_COMMUTATION_SINE: slot_of = {1'b1, 6'd12};
        `MAV_IX_COMMUTATION_COSINE: slot_of = {1'b1, 6'd13};
        `MAV_IX_ALPHA_AXIS_CURRENT: slot_of = {1'b1, 6'd14};
        `MAV_IX_BETA_AXIS_CURRENT: slot_of = {1'b1, 6'd15};
        `MAV_IX_ALPHA_AXIS_VOLTAGE: slot_of = {1'b1, 6'd16};
        `MAV_IX_BETA_AXIS_VOLTAGE: slot_of = {1'b1, 6'd17};
        `MAV_IX_D_AXIS_CURRENT_MEAS: slot_of = {1'b1, 6'd18};
        `MAV_IX_Q_AXIS_CURRENT_MEAS: slot_of = {1'b1, 6'd19};
        `MAV_IX_D_AXIS_VOLTAGE: slot_of = {1'b1, 6'd20};
        `MAV_IX_Q_AXIS_VOLTAGE: slot_of = {1'b1, 6'd21};
        `MAV_IX_ALIGN_CURRENT_TARGET: slot_of = {1'b1, 6'd22};
        `MAV_IX_OPEN_LOOP_RATE_TARGET: slot_of = {1'b1, 6'd23};
        `MAV_IX_OPEN_LOOP_CURRENT_TARGET: slot_of = {1'b1, 6'd24};
        `MAV_IX_FEEDBACK_LOOP_RATE_TARGET: slot_of = {1'b1, 6'd25};
        `MAV_IX_D_AXIS_CURRENT_TARGET: slot_of = {1'b1, 6'd26};
        `MAV_IX_Q_AXIS_CURRENT_TARGET: slot_of = {1'b1, 6'd27};
        `MAV_IX_SPIN_DETECT_STATUS: slot_of = {1'b1, SL_SPIN};
        `MAV_IX_SPIN_DETECT_RATE: slot_of = {1'b1, 6'd29};
        `MAV_IX_POSITION_DETECT_STATUS: slot_of = {1'b1, SL_POS};
        `MAV_IX_POSITION_DETECT_ANGLE: slot_of = {1'b1, 6'd31};
        `MAV_IX_D_AXIS_BACKEMF: slot_of = {1'b1, 6'd32};
        `MAV_IX_Q_AXIS_BACKEMF: slot_of = {1'b1, 6'd33};
        `MAV_IX_ROTOR_RATE_ESTIMATE: slot_of = {1'b1, 6'd34};
        `MAV_IX_ROTOR_ANGLE_ESTIMATE: slot_of = {1'b1, 6'd35};
        default: slot_of = 7'h00;
      endcase
    end
  endfunction

  // Half-word registers keep bits 31-16 at zero
  function is_narrow;
    input [5:0] sl;
    begin
      is_narrow = (sl == SL_SEQ) || (sl == SL_GAIN) || (sl == SL_VRANGE) ||
                  (sl == SL_SPIN) || (sl == SL_POS);
    end
  endfunction

  // ************************************************************
  // Sequencer code check
  // ************************************************************
  function seq_code_ok;
    input [15:0] code;
    begin
      case (code)
        `MAV_ST_IDLE: seq_code_ok = 1'b1;
        `MAV_ST_SPIN_DETECT: seq_code_ok = 1'b1;
        `MAV_ST_TRISTATE: seq_code_ok = 1'b1;
        `MAV_ST_BRAKE_ON_START: seq_code_ok = 1'b1;
        `MAV_ST_POSITION_DETECT: seq_code_ok = 1'b1;
        `MAV_ST_SLOW_FIRST_CYCLE: seq_code_ok = 1'b1;
        `MAV_ST_ALIGN: seq_code_ok = 1'b1;
        `MAV_ST_OPEN_LOOP: seq_code_ok = 1'b1;
        `MAV_ST_CL_UNALIGNED: seq_code_ok = 1'b1;
        `MAV_ST_CL_ALIGNED: seq_code_ok = 1'b1;
        `MAV_ST_CL_ACTIVE_BRAKING: seq_code_ok = 1'b1;
        `MAV_ST_SOFT_STOP: seq_code_ok = 1'b1;
        `MAV_ST_RECIRCULATE_STOP: seq_code_ok = 1'b1;
        `MAV_ST_BRAKE_ON_STOP: seq_code_ok = 1'b1;
        `MAV_ST_FAULT: seq_code_ok = 1'b1;
        `MAV_ST_PX_STOP_CHECK: seq_code_ok = 1'b1;
        `MAV_ST_PX_STOP_WAIT: seq_code_ok = 1'b1;
        `MAV_ST_PX_BRAKE: seq_code_ok = 1'b1;
        `MAV_ST_PX_PARAM_INIT: seq_code_ok = 1'b1;
        `MAV_ST_PX_RL_MEASURE: seq_code_ok = 1'b1;
        `MAV_ST_PX_STALL_MEASURE: seq_code_ok = 1'b1;
        `MAV_ST_PX_UNUSED: seq_code_ok = 1'b0;
        `MAV_ST_PX_TORQUE_MODE: seq_code_ok = 1'b1;
        `MAV_ST_PX_FAULT: seq_code_ok = 1'b1;
        default: seq_code_ok = 1'b0;
      endcase
    end
  endfunction

  function is_fault_code;
    input [15:0] code;
    begin
      is_fault_code = (code == `MAV_ST_FAULT) || (code == `MAV_ST_PX_FAULT);
    end
  endfunction

  // ************************************************************
  // Storage
  // ************************************************************
  reg [DW-1:0] mem [0:NSLOT-1];
  reg [`MAV_EV_COUNT-1:0] irq_mask;
  wire [`MAV_EV_COUNT-1:0] irq_status;

  // ************************************************************
  // Algorithm update side
  // ************************************************************
  reg [6:0] u_dec;
  reg [5:0] u_slot;
  reg u_ok;
  reg u_accept;
  reg [15:0] u_half;
  reg [15:0] cur_state;
  reg [DW-1:0] u_word;
  reg [`MAV_EV_COUNT-1:0] ev_set;

  always @* begin
    u_dec = slot_of(upd_index_i);
    u_slot = u_dec[5:0];
    u_half = upd_data_i[15:0];
    cur_state = mem[SL_SEQ][15:0];
    case (u_slot)
      SL_SEQ: u_ok = seq_code_ok(u_half);
      SL_GAIN: u_ok = (u_half <= `MAV_GAIN_X1);
      SL_VRANGE: u_ok = (u_half <= `MAV_VRANGE_MAX);
      default: u_ok = 1'b1;
    endcase
    u_accept = upd_i && u_dec[6] && u_ok;
    if (is_narrow(u_slot)) begin
      u_word = {{(DW-`MAV_NARROW_W){1'b0}}, u_half};
    end else begin
      u_word = upd_data_i;
    end
    ev_set = `MAV_RST_EVT;
    ev_set[`MAV_EV_STATE_CHANGE] = u_accept && (u_slot == SL_SEQ) && (u_half != cur_state);
    ev_set[`MAV_EV_FAULT_ENTRY] = u_accept && (u_slot == SL_SEQ) && is_fault_code(u_half) &&
                                  (u_half != cur_state);
    ev_set[`MAV_EV_SPIN_STATUS] = u_accept && (u_slot == SL_SPIN);
    ev_set[`MAV_EV_POS_STATUS] = u_accept && (u_slot == SL_POS);
    ev_set[`MAV_EV_REJECTED] = upd_i && !u_accept;
  end

  integer i;

  // Only the algorithm side ever changes stored values
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (i = 0; i < NSLOT; i = i + 1) begin
        mem[i] <= `MAV_RST_WORD;
      end
    end else if (u_accept) begin
      mem[u_slot] <= u_word;
    end
  end

  // ************************************************************
  // Host access decode
  // ************************************************************
  wire [10:0] h_index = addr_i[12:2];
  wire h_aligned = (addr_i[1:0] == 2'b00);
  wire [6:0] h_dec = slot_of(h_index);
  wire h_hit = h_aligned && h_dec[6];
  wire h_sts = h_aligned && (h_index == `MAV_IX_IRQ_STATUS);
  wire h_msk = h_aligned && (h_index == `MAV_IX_IRQ_MASK);
  wire [`MAV_EV_COUNT-1:0] ev_clr = (wr_i && h_sts) ? wdata_i[`MAV_EV_COUNT-1:0] : `MAV_RST_EVT;

  // ************************************************************
  // Interrupt status and mask
  // ************************************************************
  genvar g;
  generate
    for (g = 0; g < `MAV_EV_COUNT; g = g + 1) begin : g_evt
      mav_sticky u_flag (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .set_i(ev_set[g]),
        .clr_i(ev_clr[g]),
        .q_o(irq_status[g])
      );
    end
  endgenerate

  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_mask <= `MAV_RST_EVT;
      irq_o <= 1'b0;
    end else begin
      if (wr_i && h_msk) begin
        irq_mask <= wdata_i[`MAV_EV_COUNT-1:0];
      end
      irq_o <= |(irq_status & irq_mask);
    end
  end

  // ************************************************************
  // Host read path
  // ************************************************************
  reg [31:0] next_rdata;

  always @* begin
    next_rdata = `MAV_RST_WORD;
    if (h_hit) begin
      next_rdata = mem[h_dec[5:0]];
    end else if (h_sts) begin
      next_rdata = {{(32-`MAV_EV_COUNT){1'b0}}, irq_status};
    end else if (h_msk) begin
      next_rdata = {{(32-`MAV_EV_COUNT){1'b0}}, irq_mask};
    end
  end

  // Read data stand only in the cycle after the strobe
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_o <= `MAV_RST_WORD;
    end else if (rd_i) begin
      rdata_o <= next_rdata;
    end else begin
      rdata_o <= `MAV_RST_WORD;
    end
  end

endmodule // mav_bank

`default_nettype wire

// [testbench/mav_bank_sva.sv]
// Port checker for the algorithm variable bank
`timescale 1ns/100ps
`default_nettype none
`include "mav_consts.vh"

module mav_bank_chk (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [12:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic upd_i,
  input wire logic [10:0] upd_index_i,
  input wire logic [31:0] upd_data_i,
  input wire logic irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // ************************************************************
  // Helpers
  // ************************************************************
  logic touched;
  wire [10:0] ix = addr_i[12:2];
  wire wide_upd = upd_index_i inside {11'h440, 11'h442, 11'h444, 11'h4e2, 11'h4e4,
                                      11'h4e6, 11'h4e8, 11'h758, 11'h75c};
  // Nothing stored yet since reset
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      touched <= 1'b0;
    end else if (upd_i || wr_i) begin
      touched <= 1'b1;
    end
  end
  // ************************************************************
  // Properties
  // ************************************************************
  property p_idle_zero;
    !rd_i |=> rdata_o == 32'h0;
  endproperty
  a_idle_zero: assert property (p_idle_zero) else $error("read data not zero when idle");
  property p_fresh_zero;
    rd_i && !touched |=> rdata_o == 32'h0;
  endproperty
  a_fresh_zero: assert property (p_fresh_zero) else $error("nonzero before update");
  property p_misaligned;
    rd_i && addr_i[1:0] != 2'b00 |=> rdata_o == 32'h0;
  endproperty
  a_misaligned: assert property (p_misaligned) else $error("misaligned read nonzero");
  property p_narrow;
    rd_i && (ix == 11'h190 || ix == 11'h680 || ix == 11'h6be) |=> rdata_o[31:16] == 16'h0;
  endproperty
  a_narrow: assert property (p_narrow) else $error("narrow register upper half set");
  property p_state_code;
    rd_i && ix == 11'h190 |=> rdata_o <= 32'h17 && rdata_o != 32'h15;
  endproperty
  a_state_code: assert property (p_state_code) else $error("bad state code");
  property p_gain;
    rd_i && ix == 11'h468 |=> rdata_o <= 32'h3;
  endproperty
  a_gain: assert property (p_gain) else $error("bad gain code");
  property p_upd_visible;
    (upd_i && wide_upd) ##1 !upd_i ##1 (rd_i && !upd_i && addr_i == {$past(upd_index_i, 2), 2'b00})
      |=> rdata_o == $past(upd_data_i, 3);
  endproperty
  a_upd_visible: assert property (p_upd_visible) else $error("word not stored");
  property p_wr_ignored;
    (rd_i && !upd_i && ix < 11'h7e0) ##1 (wr_i && !upd_i && $stable(addr_i)) ##1
      (rd_i && !upd_i && $stable(addr_i)) |=> rdata_o == $past(rdata_o, 2);
  endproperty
  a_wr_ignored: assert property (p_wr_ignored) else $error("write changed bank");
  property p_irq_rise;
    $rose(irq_o) |-> $past(upd_i, 2) || $past(wr_i, 2);
  endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("interrupt rose without cause");
  property p_irq_fall;
    $fell(irq_o) |-> $past(wr_i, 2);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("interrupt fell without write");
endmodule // mav_bank_chk

bind mav_bank mav_bank_chk u_chk (.clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .upd_i(upd_i),
  .upd_index_i(upd_index_i), .upd_data_i(upd_data_i), .irq_o(irq_o));
`default_nettype wire

// [testbench/tb_top.sv]
// Self-checking bench for the algorithm variable bank
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [12:0] addr_i = 13'h0;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic upd_i = 1'b0;
  logic [10:0] upd_index_i = 11'h0;
  logic [31:0] upd_data_i = 32'h0;
  wire [31:0] rdata_o;
  wire irq_o;
  int bad_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  logic [31:0] got;

  mav_bank u_dut (.clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .upd_i(upd_i), .upd_index_i(upd_index_i),
    .upd_data_i(upd_data_i), .irq_o(irq_o));

  initial begin
    forever #20 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      tally_and_finish();
    end
  end
  // ************************************************************
  // Bus and compare tasks
  // ************************************************************
  task automatic tally_and_finish;
    $display("checks %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic check32(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic bus_write(input logic [12:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic bus_read(input logic [12:0] a, output logic [31:0] d);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    d = rdata_o;
  endtask
  task automatic expect_rd(input logic [10:0] ix, input logic [31:0] e);
    logic [31:0] d;
    bus_read({ix, 2'b00}, d);
    check32(d, e);
  endtask
  task automatic update(input logic [10:0] ix, input logic [31:0] d);
    @(posedge clk_i);
    upd_i <= 1'b1;
    upd_index_i <= ix;
    upd_data_i <= d;
    @(posedge clk_i);
    upd_i <= 1'b0;
  endtask
  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_reset;
    logic [10:0] ixs [11];
    ixs = '{11'h190, 11'h196, 11'h410, 11'h440, 11'h468, 11'h472, 11'h680, 11'h6be,
            11'h758, 11'h75c, 11'h7e0};
    foreach (ixs[i]) expect_rd(ixs[i], 32'h0);
  endtask
  task automatic t_words;
    logic [10:0] ixs [9];
    ixs = '{11'h440, 11'h442, 11'h444, 11'h4e2, 11'h4e4, 11'h4e6, 11'h4e8, 11'h758, 11'h75c};
    update(11'h440, 32'h08000000);
    expect_rd(11'h440, 32'h08000000);
    foreach (ixs[i]) begin
      update(ixs[i], {ixs[i], 10'h2a5, ~ixs[i]});
      expect_rd(ixs[i], {ixs[i], 10'h2a5, ~ixs[i]});
    end
    update(11'h680, 32'hffffa5a5);
    expect_rd(11'h680, 32'h0000a5a5);
    update(11'h6be, 32'h12345678);
    expect_rd(11'h6be, 32'h00005678);
  endtask
  task automatic t_codes;
    for (int c = 0; c < 25; c++) begin
      update(11'h190, 32'(c));
      expect_rd(11'h190, 32'(c == 21 ? 20 : c == 24 ? 23 : c));
    end
    bus_read(13'h1f80, got);
    check32({31'h0, got[4]}, 32'h1);
    for (int g = 0; g < 5; g++) begin
      update(11'h468, 32'(g));
      expect_rd(11'h468, 32'(g > 3 ? 3 : g));
    end
  endtask
  task automatic t_wr_ignore;
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= 13'h1100;
    @(posedge clk_i);
    rd_i <= 1'b0;
    wr_i <= 1'b1;
    wdata_i <= 32'hffffffff;
    @(posedge clk_i);
    wr_i <= 1'b0;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    check32(rdata_o, {11'h440, 10'h2a5, ~11'h440});
    bus_write(13'h0640, 32'h5);
    expect_rd(11'h190, 32'h17);
    bus_write(13'h1ffc, 32'h1);
    bus_read(13'h1101, got);
    check32(got, 32'h0);
  endtask
  task automatic t_irq;
    bus_write(13'h1f80, 32'h1f);
    expect_rd(11'h7e0, 32'h0);
    update(11'h190, 32'h1);
    expect_rd(11'h7e0, 32'h1);
    check32({31'h0, irq_o}, 32'h0);
    bus_write(13'h1f88, 32'h1);
    @(posedge clk_i);
    #1;
    check32({31'h0, irq_o}, 32'h1);
    bus_write(13'h1f80, 32'h1);
    @(posedge clk_i);
    #1;
    check32({31'h0, irq_o}, 32'h0);
    expect_rd(11'h7e2, 32'h1);
    update(11'h190, 32'he);
    update(11'h680, 32'h3);
    update(11'h6be, 32'h4);
    update(11'h472, 32'h3);
    expect_rd(11'h7e0, 32'h1f);
    expect_rd(11'h472, 32'h0);
    update(11'h472, 32'h2);
    expect_rd(11'h472, 32'h2);
    expect_rd(11'h190, 32'he);
    // Event and clear in one cycle, set must win
    @(posedge clk_i);
    upd_i <= 1'b1;
    upd_index_i <= 11'h680;
    wr_i <= 1'b1;
    addr_i <= 13'h1f80;
    wdata_i <= 32'h1f;
    @(posedge clk_i);
    upd_i <= 1'b0;
    wr_i <= 1'b0;
    expect_rd(11'h7e0, 32'h4);
    expect_rd(11'h680, 32'h2);
    bus_write(13'h1f88, 32'h4);
    @(posedge clk_i);
    #1;
    check32({31'h0, irq_o}, 32'h1);
  endtask
  initial begin
    repeat (2) @(posedge clk_i);
    rstn_i <= 1'b1;
    t_reset();
    t_words();
    t_codes();
    t_wr_ignore();
    t_irq();
    tally_and_finish();
  end
endmodule // tb_top
`default_nettype wire
